// ==== src/ccem_pkg.sv ====
// Constants, codes and carrier types of the cam control error manager.
// Assumes a 250 MHz controller cycle clock and an APB register port.
package ccem_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int OVL_TIME_US = 1000; // Sustained overcurrent before trip
   localparam int OVL_CYC = OVL_TIME_US * CLK_MHZ;
   localparam int BLANK_TIME_US = 1; // All-off pulse after overload ack
   localparam int BLANK_CYC = BLANK_TIME_US * CLK_MHZ;
   // ------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_CMD = 12'h004;
   localparam logic [11:0] ADDR_STAT = 12'h008;
   localparam logic [11:0] ADDR_CFG = 12'h00C;
   localparam logic [11:0] ADDR_IDLE = 12'h010;
   localparam int CTRL_LOCK_BIT = 8;
   localparam int CMD_A1_LSB = 8;
   localparam int CMD_A2_LSB = 16;
   localparam logic [15:0] RES_RST = 16'h0400;
   localparam logic [1:0] DIR_MAX = 2'h2;
   // ------------------------------------------------------------
   // Error codes and class bounds
   // ------------------------------------------------------------
   localparam logic [7:0] ST_MIN = 8'h01;
   localparam logic [7:0] ST_MAX = 8'h13;
   localparam logic [7:0] WARN_MIN = 8'h14;
   localparam logic [7:0] WARN_MAX = 8'h63;
   localparam logic [7:0] E_NV_WR = 8'h14;
   localparam logic [7:0] E_ZERO = 8'h15;
   localparam logic [7:0] E_CAM = 8'h16;
   localparam logic [7:0] E_DEL = 8'h18;
   localparam logic [7:0] E_PERMIT = 8'h1E;
   localparam logic [7:0] E_OVL = 8'h1F;
   localparam logic [7:0] E_FULL = 8'h20;
   localparam logic [7:0] E_DUP = 8'h21;
   localparam logic [7:0] E_PART = 8'h22;
   localparam logic [7:0] E_RES = 8'h23;
   localparam logic [7:0] E_IDLE = 8'h26;
   localparam logic [7:0] E_NOITC = 8'h27;
   localparam logic [7:0] E_TX = 8'h28;
   localparam logic [7:0] E_RX = 8'h29;
   localparam logic [7:0] E_ID = 8'h2A;
   localparam logic [7:0] E_BUS = 8'h2B;
   localparam logic [7:0] E_RXOVF = 8'h2C;
   localparam logic [7:0] E_DIR = 8'h2F;
   localparam logic [7:0] E_BRAKE = 8'h32;
   localparam logic [7:0] RESTRICT_OUTS = 8'h08;

   typedef enum logic [3:0] {
      OP_NONE = 4'h0, OP_DEL_PARAM = 4'h1, OP_STORE = 4'h2, OP_CAM_ON = 4'h3,
      OP_PART_ITC = 4'h4, OP_RESOL = 4'h5, OP_IDLE = 4'h6, OP_ITC_EN = 4'h7,
      OP_DIR = 4'h8
   } ccem_op_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ccem_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ccem_apb_rsp_t;
   typedef struct packed {
      logic wr_fail;
      logic zero_fail;
      logic cam_fail;
   } ccem_nv_ev_t;
   typedef struct packed {
      logic tx_fail;
      logic tx_ok;
      logic rx_fail;
      logic rx_ok;
      logic id_conflict;
      logic line_fault;
      logic bus_err;
      logic rx_byte;
      logic rx_full;
   } ccem_net_ev_t;

   function automatic logic is_warn(input logic [7:0] c);
      return (c >= WARN_MIN) && (c <= WARN_MAX);
   endfunction
endpackage

// ==== src/ccem_sync.sv ====
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
module ccem_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ccem_sync_st_t;
   ccem_sync_st_t st_r, st_nxt;

   // First stage feeds only the second
   always_comb begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule

// ==== src/ccem_top.sv ====
// Error classification and reaction for an electronic cam controller.
// Assumes cam_in is the pattern computed from the encoder this cycle and
// that event inputs are one-cycle pulses from logic on ref_clk.
//
// Notes on behaviour
// RQ1: Every detected error puts its numeric code on the display; warnings do not replace a pending self-test or serious code.
// RQ2: Error stays shown until acknowledged by escape or enter key per variant.
// RQ3: Codes 1..19 are self-test faults; the unit is marked defective.
// RQ4: During warnings 20..99 outputs keep following the encoder every cycle.
// RQ5: Distinct codes 20, 21, 22 for write, zero-offset and cam save failures.
// RQ6: Deleting a parameter outside program zero is refused with code 24.
// RQ7: Modification without permit input or lockable permit is refused, code 30.
// RQ8: Sustained overcurrent switches off only that output and raises 31.
// RQ9: Acknowledging 31 briefly forces all outputs off before updating resumes.
// RQ10: Store attempt with all record slots used is refused with code 32.
// RQ11: Second cam with same switch-on position on a track gives 33.
// RQ12: Partial idle-time compensation without that option gives 34.
// RQ13: Encoder resolution not a power of two is refused with 35.
// RQ14: Restricted variant refuses idle time beyond output eight with 38.
// RQ15: Enabling compensation on units without it gives 39.
// RQ16: Two failed sends give 40; two failed receptions give 41.
// RQ17: Duplicate device number or faulty line gives 42; bus errors give 43.
// RQ18: Serial byte arriving with full receive buffer gives 44.
// RQ19: Illegal direction-dependent update setting is refused with 47.
// RQ20: Brake-cam units raise 50 whenever outputs are deactivated; here only when an overload acknowledge blanks the outputs.
// RQ21: Serious codes 100..199 hold all outputs off while the cause remains.
// RQ22: Latest code latched until acknowledged; refused requests change nothing.
`timescale 1ns/1ps
module ccem_top #(
   parameter int NOUT = 16,
   parameter int NSLOT = 64,
   parameter int unsigned OVL_CYCLES = ccem_pkg::OVL_CYC,
   parameter bit PC_PROG = 1'b0,
   parameter bit RESTRICTED = 1'b0,
   parameter bit HAS_ITC = 1'b1,
   parameter bit HAS_PART_ITC = 1'b0,
   parameter bit BRAKE_OPT = 1'b0
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire ccem_pkg::ccem_apb_req_t apb_req,
   output ccem_pkg::ccem_apb_rsp_t apb_rsp,
   input wire logic esc_key_pin,
   input wire logic enter_key_pin,
   input wire logic prog_permit_pin,
   input wire logic [NOUT-1:0] overcurrent_pin,
   input wire logic [NOUT-1:0] cam_in,
   output logic [NOUT-1:0] cam_out,
   input wire logic selftest_fail,
   input wire logic [7:0] selftest_code,
   input wire logic serious_active,
   input wire logic [7:0] serious_code,
   input wire ccem_pkg::ccem_nv_ev_t nv_ev,
   input wire ccem_pkg::ccem_net_ev_t net_ev,
   output logic [7:0] err_code,
   output logic err_pending,
   output logic unit_defective
);
   localparam int CW = $clog2(OVL_CYCLES + 1);
   localparam int BW = $clog2(ccem_pkg::BLANK_CYC + 1);
   localparam int TW = (NOUT > 1) ? $clog2(NOUT) : 1;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] prog_sel;
      logic lock_permit;
      logic [15:0] resolution;
      logic itc_en;
      logic part_itc;
      logic [1:0] dir_mode;
      logic [NOUT-1:0] idle_mask;
      logic [7:0] slots;
      logic [NOUT-1:0][7:0] trk_on;
      logic [NOUT-1:0] trk_vld;
      logic [7:0] code;
      logic pend;
      logic defect;
      logic [NOUT-1:0] ovl_off;
      logic [NOUT-1:0][CW-1:0] ovl_cnt;
      logic [BW-1:0] blank;
      logic tx_once;
      logic rx_once;
      logic ser_q;
      logic key_q;
      logic [NOUT-1:0] cam;
      logic [31:0] prdata;
      logic pslverr;
   } ccem_st_t;
   ccem_st_t q, d;

   logic [NOUT+2:0] pins_s;
   logic esc_s, enter_s, permit_s, key_s, key_edge;
   logic [NOUT-1:0] ovl_s;

   // Keys, permit and overcurrent sense are pins
   ccem_sync #(.W(NOUT + 3)) u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .d({overcurrent_pin, prog_permit_pin, enter_key_pin, esc_key_pin}),
      .q(pins_s)
   );
   assign esc_s = pins_s[0];
   assign enter_s = pins_s[1];
   assign permit_s = pins_s[2];
   assign ovl_s = pins_s[NOUT+2:3];
   // Only the key of this variant acknowledges
   assign key_s = PC_PROG ? enter_s : esc_s; // RQ2
   assign key_edge = key_s & ~q.key_q;

   // ------------------------------------------------------------
   // Bus decode and command fields
   // ------------------------------------------------------------
   logic apb_wr, apb_setup, cmd_wr, permit;
   ccem_pkg::ccem_op_t op;
   logic [7:0] a1;
   logic [15:0] a2;
   logic [TW-1:0] trk;
   assign apb_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign apb_setup = apb_req.psel & ~apb_req.penable;
   assign cmd_wr = apb_wr && (apb_req.paddr == ccem_pkg::ADDR_CMD);
   assign op = ccem_pkg::ccem_op_t'(apb_req.pwdata[3:0]);
   assign a1 = apb_req.pwdata[ccem_pkg::CMD_A1_LSB +: 8];
   assign a2 = apb_req.pwdata[ccem_pkg::CMD_A2_LSB +: 16];
   assign trk = a1[TW-1:0];
   assign permit = permit_s | q.lock_permit;

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   logic cmd_rej, warn_ev, warn_ok, ovl_trip, brake_ev, force_off, ser_rise;
   logic [7:0] cmd_code, warn_code;

   // Commands are checked in full before anything is stored
   always_comb begin
      d = q;
      cmd_rej = 1'b0;
      cmd_code = 8'h00;
      warn_ev = 1'b0;
      warn_code = 8'h00;
      ovl_trip = 1'b0;
      brake_ev = 1'b0;
      ser_rise = serious_active & ~q.ser_q;
      d.ser_q = serious_active;
      d.key_q = key_s;

      // Register writes
      if (apb_wr && apb_req.paddr == ccem_pkg::ADDR_CTRL) begin
         d.prog_sel = apb_req.pwdata[7:0];
         d.lock_permit = apb_req.pwdata[ccem_pkg::CTRL_LOCK_BIT];
      end
      if (cmd_wr && op != ccem_pkg::OP_NONE) begin
         if (!permit) begin
            cmd_rej = 1'b1; // RQ7
            cmd_code = ccem_pkg::E_PERMIT;
         end else begin
            unique case (op)
               ccem_pkg::OP_DEL_PARAM: begin
                  if (q.prog_sel != 8'h00) begin
                     cmd_rej = 1'b1; // RQ6
                     cmd_code = ccem_pkg::E_DEL;
                  end else begin
                     d.idle_mask = '0;
                  end
               end
               ccem_pkg::OP_STORE: begin
                  if (q.slots >= 8'(NSLOT)) begin
                     cmd_rej = 1'b1; // RQ10
                     cmd_code = ccem_pkg::E_FULL;
                  end else begin
                     d.slots = q.slots + 8'h01;
                  end
               end
               ccem_pkg::OP_CAM_ON: begin
                  if (a1 < 8'(NOUT)) begin
                     if (q.trk_vld[trk] && q.trk_on[trk] == a2[7:0]) begin
                        cmd_rej = 1'b1; // RQ11
                        cmd_code = ccem_pkg::E_DUP;
                     end else begin
                        d.trk_on[trk] = a2[7:0];
                        d.trk_vld[trk] = 1'b1;
                     end
                  end
               end
               ccem_pkg::OP_PART_ITC: begin
                  if (!HAS_PART_ITC) begin
                     cmd_rej = 1'b1; // RQ12
                     cmd_code = ccem_pkg::E_PART;
                  end else begin
                     d.part_itc = 1'b1;
                  end
               end
               ccem_pkg::OP_RESOL: begin
                  if (a2 == 16'h0000 || (a2 & (a2 - 16'h0001)) != 16'h0000) begin
                     cmd_rej = 1'b1; // RQ13
                     cmd_code = ccem_pkg::E_RES;
                  end else begin
                     d.resolution = a2;
                  end
               end
               ccem_pkg::OP_IDLE: begin
                  if (RESTRICTED && a1 >= ccem_pkg::RESTRICT_OUTS) begin
                     cmd_rej = 1'b1; // RQ14
                     cmd_code = ccem_pkg::E_IDLE;
                  end else if (a1 < 8'(NOUT)) begin
                     d.idle_mask[trk] = 1'b1;
                  end
               end
               ccem_pkg::OP_ITC_EN: begin
                  if (!HAS_ITC) begin
                     cmd_rej = 1'b1; // RQ15
                     cmd_code = ccem_pkg::E_NOITC;
                  end else begin
                     d.itc_en = 1'b1;
                  end
               end
               ccem_pkg::OP_DIR: begin
                  if (a1 > 8'(ccem_pkg::DIR_MAX)) begin
                     cmd_rej = 1'b1; // RQ19
                     cmd_code = ccem_pkg::E_DIR;
                  end else begin
                     d.dir_mode = a1[1:0];
                  end
               end
               default: begin
               end
            endcase
         end
      end

      // Overload: per-output sustain counter, trip switches off that output only
      for (int i = 0; i < NOUT; i++) begin
         if (ovl_s[i] && !q.ovl_off[i]) begin
            if (q.ovl_cnt[i] == CW'(OVL_CYCLES - 1)) begin
               d.ovl_off[i] = 1'b1; // RQ8
               d.ovl_cnt[i] = '0;
               ovl_trip = 1'b1;
            end else begin
               d.ovl_cnt[i] = q.ovl_cnt[i] + CW'(1);
            end
         end else begin
            d.ovl_cnt[i] = '0;
         end
      end

      // Network: a second consecutive failure raises the warning
      if (net_ev.tx_ok) d.tx_once = 1'b0;
      if (net_ev.tx_fail) d.tx_once = ~q.tx_once;
      if (net_ev.rx_ok) d.rx_once = 1'b0;
      if (net_ev.rx_fail) d.rx_once = ~q.rx_once;

      // Acknowledge; a serious cause or a defective unit keeps the code shown
      if (q.blank != '0) d.blank = q.blank - BW'(1);
      if (key_edge && q.pend && !serious_active && !q.defect) begin
         d.pend = 1'b0; // RQ2
         if (q.code == ccem_pkg::E_OVL) begin
            d.ovl_off = d.ovl_off & ~q.ovl_off; // A trip in this very cycle survives the clear
            d.ovl_cnt = '0;
            d.blank = BW'(ccem_pkg::BLANK_CYC); // RQ9
            brake_ev = BRAKE_OPT; // RQ20
         end
      end

      // Warning sources, later lines take priority
      if (nv_ev.wr_fail) begin warn_ev = 1'b1; warn_code = ccem_pkg::E_NV_WR; end // RQ5
      if (nv_ev.zero_fail) begin warn_ev = 1'b1; warn_code = ccem_pkg::E_ZERO; end // RQ5
      if (nv_ev.cam_fail) begin warn_ev = 1'b1; warn_code = ccem_pkg::E_CAM; end // RQ5
      if (net_ev.tx_fail && q.tx_once) begin warn_ev = 1'b1; warn_code = ccem_pkg::E_TX; end // RQ16
      if (net_ev.rx_fail && q.rx_once) begin warn_ev = 1'b1; warn_code = ccem_pkg::E_RX; end // RQ16
      if (net_ev.bus_err) begin warn_ev = 1'b1; warn_code = ccem_pkg::E_BUS; end // RQ17
      if (net_ev.id_conflict || net_ev.line_fault) begin
         warn_ev = 1'b1; // RQ17
         warn_code = ccem_pkg::E_ID;
      end
      if (net_ev.rx_byte && net_ev.rx_full) begin warn_ev = 1'b1; warn_code = ccem_pkg::E_RXOVF; end // RQ18
      if (ovl_trip) begin warn_ev = 1'b1; warn_code = ccem_pkg::E_OVL; end // RQ8
      if (brake_ev) begin warn_ev = 1'b1; warn_code = ccem_pkg::E_BRAKE; end // RQ20
      if (cmd_rej) begin warn_ev = 1'b1; warn_code = cmd_code; end

      // Latch: a warning never hides a pending self-test or serious code;
      // a new event wins over an acknowledge in the same cycle, except a warning while a serious code is acknowledged
      warn_ok = !(q.pend && !ccem_pkg::is_warn(q.code));
      if (selftest_fail && selftest_code >= ccem_pkg::ST_MIN && selftest_code <= ccem_pkg::ST_MAX) begin
         d.code = selftest_code; // RQ3
         d.pend = 1'b1;
         d.defect = 1'b1;
      end else if (ser_rise) begin
         d.code = serious_code; // RQ21
         d.pend = 1'b1;
      end else if (warn_ev && warn_ok) begin
         d.code = warn_code; // RQ22
         d.pend = 1'b1; // RQ1
      end

      // Outputs follow the encoder pattern each cycle unless forced off
      force_off = serious_active | d.defect | (d.blank != '0); // RQ21
      d.cam = force_off ? '0 : (cam_in & ~d.ovl_off); // RQ4

      // Read data is prepared in the setup phase for a zero-wait access
      if (apb_setup) begin
         d.pslverr = 1'b0;
         d.prdata = 32'h0000_0000;
         unique case (apb_req.paddr)
            ccem_pkg::ADDR_CTRL: d.prdata = {23'h000000, q.lock_permit, q.prog_sel};
            ccem_pkg::ADDR_CMD: d.prdata = 32'h0000_0000;
            ccem_pkg::ADDR_STAT: d.prdata = {16'(q.ovl_off), 4'h0, serious_active,
                                             q.blank != '0, q.defect, q.pend, q.code};
            ccem_pkg::ADDR_CFG: d.prdata = {q.slots, 4'h0, q.dir_mode, q.part_itc, q.itc_en, q.resolution};
            ccem_pkg::ADDR_IDLE: d.prdata = 32'(q.idle_mask);
            default: d.pslverr = 1'b1;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers and outputs
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         q <= '0;
         q.resolution <= ccem_pkg::RES_RST;
      end else begin
         q <= d;
      end
   end

   // Zero wait states: the answer is ready in every access cycle
   assign apb_rsp = '{prdata: q.prdata, pready: 1'b1, pslverr: q.pslverr};
   assign cam_out = q.cam;
   assign err_code = q.code;
   assign err_pending = q.pend;
   assign unit_defective = q.defect;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking ccem_cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   logic [28+10*NOUT-1:0] cfg_view;
   assign cfg_view = {q.resolution, q.itc_en, q.part_itc, q.dir_mode, q.idle_mask,
                      q.slots, q.trk_on, q.trk_vld};

   selftest_show_a: assert property (selftest_fail && selftest_code == 8'h05 |=> // RQ3
      err_code == 8'h05 && err_pending && unit_defective)
      else $error("self-test code not shown");
   pend_hold_a: assert property (err_pending && !key_edge |=> err_pending) // RQ2
      else $error("error cleared without acknowledge");
   serious_off_a: assert property (serious_active |=> cam_out == '0) // RQ21
      else $error("outputs on during serious fault");
   warn_update_a: assert property (err_pending && ccem_pkg::is_warn(err_code) && !force_off // RQ4
      |=> cam_out == ($past(cam_in) & ~q.ovl_off))
      else $error("outputs not updated during warning");
   del_refuse_a: assert property (cmd_wr && op == ccem_pkg::OP_DEL_PARAM && permit && // RQ6
      q.prog_sel != 8'h00 && !selftest_fail && !ser_rise && warn_ok |=> err_code == ccem_pkg::E_DEL)
      else $error("delete outside program zero accepted");
   permit_a: assert property (cmd_wr && op != ccem_pkg::OP_NONE && !permit && !selftest_fail // RQ7
      && !ser_rise && warn_ok |=> err_code == ccem_pkg::E_PERMIT && err_pending)
      else $error("modification without permit accepted");
   reject_keep_a: assert property (cmd_rej |=> $stable(cfg_view)) // RQ22
      else $error("refused request changed configuration");
   ovl_isolate_a: assert property ((q.ovl_off & cam_out) == '0) // RQ8
      else $error("tripped output still driven");
   blank_a: assert property (key_edge && err_pending && err_code == ccem_pkg::E_OVL && // RQ9
      !serious_active && !unit_defective |=> (cam_out == '0) [*8])
      else $error("outputs not blanked after overload acknowledge");
   rxovf_a: assert property (net_ev.rx_byte && net_ev.rx_full && !cmd_rej && !ovl_trip && // RQ18
      !brake_ev && !selftest_fail && !ser_rise && warn_ok |=> err_code == ccem_pkg::E_RXOVF)
      else $error("receive overflow not raised");

   warn_seen_c: cover property (err_pending && ccem_pkg::is_warn(err_code) ##[1:20] !err_pending);
   ovl_ack_c: cover property (ovl_trip ##[1:50] key_edge);
   serious_c: cover property (ser_rise ##[1:40] !serious_active);
endmodule

// ==== test/ccem_term.sv ====
// Operator terminal model: presses the acknowledge key when asked to.
// Assumes the error manager samples the key pins through a synchroniser.
`timescale 1ns/1ps
module ccem_term #(
   parameter bit PC_PROG = 1'b0
) (
   input wire logic ref_clk,
   input wire logic ack_go,
   output logic esc_key_pin,
   output logic enter_key_pin
);
   logic [2:0] hold_r = 3'h0;
   // Key held four cycles so that the two-stage synchroniser surely sees it
   always @(posedge ref_clk) begin
      if (ack_go) hold_r <= 3'h4;
      else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
   end
   // Only the key of the configured variant is pressed
   assign esc_key_pin = !PC_PROG && (hold_r != 3'h0);
   assign enter_key_pin = PC_PROG && (hold_r != 3'h0);
endmodule

// ==== test/cam_control_error_manager_tb_top.sv ====
// Self-checking bench of the cam control error manager.
// Assumes a short overload time and two record slots to keep the run brief,
// and a restricted, no-compensation, brake-cam variant.
`timescale 1ns/1ps
module cam_control_error_manager_tb_top;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   ccem_pkg::ccem_apb_req_t req = '0;
   ccem_pkg::ccem_apb_rsp_t rsp;
   logic permit = 1'b0, ack_go = 1'b0, st_fail = 1'b0, ser = 1'b0, esc, ent, pend, defect, er;
   logic [15:0] ovc = 16'h0000, cam_in = 16'h0000, cam_out;
   logic [7:0] st_code = 8'h00, ser_code = 8'h00, err_code;
   ccem_pkg::ccem_nv_ev_t nv = '0;
   ccem_pkg::ccem_net_ev_t net = '0;
   logic [31:0] rd;
   int fail_count = 0, cmp_count = 0, i, k;
   // Event table: network and storage pulses with the code each raises
   localparam logic [8:0] NET_T [0:8] = '{9'h000, 9'h000, 9'h000, 9'h100, 9'h040, 9'h010, 9'h008, 9'h004, 9'h003};
   localparam logic [2:0] NV_T [0:8] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
   localparam logic [7:0] EV_C [0:8] = '{8'h14, 8'h15, 8'h16, 8'h28, 8'h29, 8'h2A, 8'h2A, 8'h2B, 8'h2C};
   // Command table; code zero means the command is accepted
   localparam logic [3:0] CM_OP [0:9] = '{4'h1, 4'h5, 4'h4, 4'h8, 4'h3, 4'h3, 4'h2, 4'h2, 4'h2, 4'h5};
   localparam logic [7:0] CM_A1 [0:9] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [15:0] CM_A2 [0:9] = '{16'h0, 16'h3, 16'h0, 16'h0, 16'h7, 16'h7, 16'h0, 16'h0, 16'h0, 16'h800};
   localparam logic [7:0] CM_C [0:9] = '{8'h18, 8'h23, 8'h22, 8'h2F, 8'h00, 8'h21, 8'h00, 8'h00, 8'h20, 8'h00};

   ccem_top #(.OVL_CYCLES(20), .NSLOT(2), .RESTRICTED(1'b1), .HAS_ITC(1'b0), .BRAKE_OPT(1'b1))
      uut (.ref_clk(ref_clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
      .esc_key_pin(esc), .enter_key_pin(ent), .prog_permit_pin(permit), .overcurrent_pin(ovc), .cam_in(cam_in),
      .cam_out(cam_out), .selftest_fail(st_fail), .selftest_code(st_code), .serious_active(ser),
      .serious_code(ser_code), .nv_ev(nv), .net_ev(net), .err_code(err_code), .err_pending(pend),
      .unit_defective(defect));
   ccem_term term (.ref_clk(ref_clk), .ack_go(ack_go), .esc_key_pin(esc), .enter_key_pin(ent));

   initial forever #2 ref_clk = ~ref_clk;
   // Encoder pattern changes every cycle so a stuck output shows at once
   always @(posedge ref_clk) cam_in <= 16'($urandom);

   function automatic logic [15:0] exp_cam(input logic [15:0] c, input logic [15:0] off);
      return c & ~off;
   endfunction
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge ref_clk);
      req.penable <= 1'b1;
      do @(posedge ref_clk); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic cmd(input logic [3:0] op, input logic [7:0] a1, input logic [15:0] a2);
      apb(1'b1, ccem_pkg::ADDR_CMD, {a2, a1, 4'h0, op});
   endtask
   task automatic wait_err(input logic [7:0] c);
      for (int j = 0; j < 400 && !(pend === 1'b1 && err_code === c); j++) @(posedge ref_clk);
      chk("err_code", {23'h0, pend, err_code}, {23'h0, 1'b1, c});
   endtask
   task automatic ack();
      ack_go <= 1'b1;
      @(posedge ref_clk);
      ack_go <= 1'b0;
      for (int j = 0; j < 50 && pend !== 1'b0; j++) @(posedge ref_clk);
      chk("pending", {31'h0, pend}, 32'h0);
   endtask
   task automatic follow(input logic [15:0] off, input int n);
      logic [15:0] x;
      repeat (n) begin
         x = cam_in;
         @(posedge ref_clk);
         chk("cam_out", {16'h0, cam_out}, {16'h0, exp_cam(x, off)});
      end
   endtask
   task automatic off_chk(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         chk("cam_off", {16'h0, cam_out}, 32'h0);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Watchdog well beyond the several hundred cycles the tests need
   initial begin
      #400000;
      fail_count++;
      complete_run();
   end

   initial begin
      void'($urandom(32'hB8B5));
      tick(4);
      reset <= 1'b0;
      tick(3);
      chk("idle", {22'h0, defect, pend, err_code}, 32'h0);
      apb(1'b0, ccem_pkg::ADDR_CFG, 32'h0);
      chk("cfg_res", {16'h0, rd[15:0]}, 32'h0400);
      follow(16'h0, 8);
      $display("test reset done");
      for (i = 0; i < 9; i++) begin
         net <= NET_T[i];
         nv <= NV_T[i];
         tick(2);
         net <= '0;
         nv <= '0;
         wait_err(EV_C[i]);
         follow(16'h0, 4);
         ack();
      end
      $display("test events done");
      cmd(4'h5, 8'h00, 16'h0800);
      wait_err(8'h1E);
      ack();
      permit <= 1'b1;
      tick(3);
      cmd(4'h8, 8'h01, 16'h0000);
      permit <= 1'b0;
      apb(1'b1, ccem_pkg::ADDR_CTRL, 32'h0000_0105);
      for (i = 0; i < 10; i++) begin
         cmd(CM_OP[i], CM_A1[i], CM_A2[i]);
         if (CM_C[i] == 8'h00) begin
            tick(4);
            chk("accepted", {31'h0, pend}, 32'h0);
         end else begin
            wait_err(CM_C[i]);
            ack();
         end
      end
      cmd(4'h6, 8'h09, 16'h0000);
      wait_err(8'h26);
      ack();
      cmd(4'h7, 8'h00, 16'h0000);
      wait_err(8'h27);
      ack();
      cmd(4'h6, 8'h03, 16'h0000);
      apb(1'b0, ccem_pkg::ADDR_IDLE, 32'h0);
      chk("idle_mask", rd, 32'h0000_0008);
      apb(1'b0, ccem_pkg::ADDR_CFG, 32'h0);
      chk("cfg", {6'h0, rd[31:24], rd[19:18], rd[15:0]}, {6'h0, 8'h02, 2'h1, 16'h0800});
      apb(1'b0, 12'h020, 32'h0);
      chk("slverr", {31'h0, er}, 32'h1);
      $display("test commands done");
      k = $urandom_range(15, 0);
      ovc[k] <= 1'b1;
      wait_err(8'h1F);
      apb(1'b0, ccem_pkg::ADDR_STAT, 32'h0);
      chk("stat", rd, {16'h1 << k, 8'h01, 8'h1F});
      follow(16'h1 << k, 6);
      ovc <= 16'h0000;
      tick(3);
      ack_go <= 1'b1;
      tick(1);
      ack_go <= 1'b0;
      wait_err(8'h32);
      off_chk(20);
      ack();
      tick(240);
      follow(16'h0, 6);
      $display("test overload done");
      ser_code <= 8'h64;
      ser <= 1'b1;
      wait_err(8'h64);
      off_chk(10);
      ack_go <= 1'b1;
      tick(1);
      ack_go <= 1'b0;
      tick(10);
      chk("held", {31'h0, pend}, 32'h1);
      ser <= 1'b0;
      tick(2);
      ack();
      follow(16'h0, 4);
      $display("test serious done");
      st_code <= 8'h05;
      st_fail <= 1'b1;
      tick(1);
      st_fail <= 1'b0;
      wait_err(8'h05);
      chk("defective", {31'h0, defect}, 32'h1);
      off_chk(5);
      $display("test selftest done");
      complete_run();
   end
endmodule
